/* File: design/wx_defines.vh */
// Constants for the waveform extension block: register map, field positions,
// reset values and fault encodings.
// Assumes inclusion by bare name from the design files.
`ifndef WX_DEFINES_VH
`define WX_DEFINES_VH

// ----------------------------------------------------------------------------
// Register map (word addresses, one aligned word each)
// ----------------------------------------------------------------------------
`define WX_ADDR_W 4
`define WX_REG_CTRL 4'h0
`define WX_REG_FDMASK 4'h1
`define WX_REG_FDCTRL 4'h2
`define WX_REG_STATUS 4'h3
`define WX_REG_OVEN 4'h4
`define WX_REG_DTBOTH 4'h5
`define WX_REG_LOW_SIDE_DELAY_VALUE 4'h6
`define WX_REG_HIGH_SIDE_DELAY_VALUE 4'h7
`define WX_REG_DTLSBUF 4'h8
`define WX_REG_DTHSBUF 4'h9
`define WX_REG_PORT 4'ha

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define WX_CTRL_PGM 5
`define WX_CTRL_CWCM 4
`define WX_CTRL_W 6
`define WX_CTRL_RST 6'h00
`define WX_FD_HALT 5
`define WX_FD_DBD 4
`define WX_FD_MODE 2
`define WX_FDCTRL_W 6
`define WX_FDCTRL_RST 6'h00
`define WX_BYTE_RST 8'h00
`define WX_CNT_ZERO 8'h00
`define WX_CNT_ONE 8'h01
`define WX_NCH 4
`define WX_NPIN 8
`define WX_FLAG_FDF 0
`define WX_FLAG_ACT 1
`define WX_RDATA_ZERO 32'h00000000

`endif

/* File: design/wx_sync2.v */
// Two flip-flop level synchroniser for inputs from outside the clock domain.
// Assumes the reset input is already synchronised to the clock.
`timescale 1ns/1ps
`default_nettype none

module wx_sync2 #(
    parameter W = 1
) (
    input wire clk_i,
    input wire rst_b_i,
    input wire [W-1:0] d_i,
    output reg [W-1:0] q_o
);

reg [W-1:0] stage1;

always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        stage1 <= {W{1'b0}};
        q_o <= {W{1'b0}};
    end else begin
        stage1 <= d_i;
        q_o <= stage1;
    end
end

endmodule // wx_sync2
`default_nettype wire

/* File: design/wx_dead_band_inserter.v */
// One dead-time generator: splits a waveform into low and high side outputs.
// Assumes waveform input on the same clock and delay values held stable.
`timescale 1ns/1ps
`default_nettype none
`include "wx_defines.vh"

module wx_dead_band_inserter (
    input wire clk_i,
    input wire rst_b_i,
    input wire wave_i,
    input wire [7:0] low_side_delay_value_i,
    input wire [7:0] high_side_delay_value_i,
    output reg low_side_out_o,
    output reg high_side_out_o,
    output wire busy_o
);

reg [7:0] count;
reg wave_d;
reg [7:0] next_count;

assign busy_o = (count != `WX_CNT_ZERO);

always @* begin
    next_count = count;
    if (wave_i && !wave_d) begin
        next_count = low_side_delay_value_i;
    end else if (!wave_i && wave_d) begin
        next_count = high_side_delay_value_i;
    end else if (count != `WX_CNT_ZERO) begin
        next_count = count - `WX_CNT_ONE;
    end
end

always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        count <= `WX_CNT_ZERO;
        wave_d <= 1'b0;
        low_side_out_o <= 1'b0;
        high_side_out_o <= 1'b0;
    end else begin
        count <= next_count;
        wave_d <= wave_i;
        if (next_count != `WX_CNT_ZERO) begin
            low_side_out_o <= 1'b0;
            high_side_out_o <= 1'b0;
        end else begin
            low_side_out_o <= wave_i;
            high_side_out_o <= ~wave_i;
        end
    end
end

endmodule // wx_dead_band_inserter
`default_nettype wire

/* File: design/wx_waveform_extension.v */
// Waveform extension top: register file on Avalon-MM, four dead-band
// inserters, pattern generator, port override and fault protection.
// Assumes timer waveforms, update strobe and port enables come from logic on
// sys_clk_i; fault events and debug break arrive asynchronously.
//
// The implementer's own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "wx_defines.vh"

// What this block does
// - Outside pattern mode, each enabled dead-band channel splits its waveform into low side and inverted high side.
// - Dead-band output replaces the normal port value on pins whose channel dead-band enable is set.
// - A set channel dead-band enable hands that pin pair to the extension.
// - Owned pins are driven per override enable, not compare output enable.
// - Both sides stay low during dead time; with a zero delay value both switch in the same cycle.
// - Four identical dead-time generators, one per compare channel.
// - One shared setting holds separate high and low dead-time values.
// - Dead-time settings are double buffered, taking effect on transfer.
// - Each 8-bit counter decrements each clock and stops at zero.
// - Nonzero counter forces both outputs off.
// - Rising edge reloads low-side value, falling edge high-side value.
// - Optional timer halt while dead time is inserted.
// - Pattern mode reuses dead-time storage and drives pattern across pins.
// - Pattern mode bypasses the dead-band stage.
// - Pattern mode drives first-channel waveform on pins with override set.
// - Pattern registers are double buffered.
// - Buffered values copy to active only at the timer update condition.
// - Any masked event triggers a fault disabling the owned outputs, or every pin in pattern mode.
// - Fault action within three clock cycles of the event.
// - Latched mode resumes after fault gone, flag cleared, next update.
// - Cycle-by-cycle mode resumes after fault gone at next update.
module wx_waveform_extension (
    input wire sys_clk_i,
    input wire rst_b_i,
    input wire [3:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    output reg [31:0] avs_readdata_o,
    output reg avs_waitrequest_o,
    input wire [3:0] waveform_gen_i,
    input wire [7:0] port_normal_i,
    input wire [7:0] compare_output_enable_i,
    input wire update_i,
    input wire [7:0] fault_event_i,
    input wire debug_break_i,
    output reg [7:0] port_out_o,
    output reg [7:0] port_oe_o,
    output reg timer_halt_o,
    output reg fault_o
);

// ----------------------------------------------------------------------------
// Reset and input synchronisation
// ----------------------------------------------------------------------------
reg rst_s1;
reg rst_b;
always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        rst_s1 <= 1'b0;
        rst_b <= 1'b0;
    end else begin
        rst_s1 <= 1'b1;
        rst_b <= rst_s1;
    end
end

wire [8:0] async_sync;
wx_sync2 #(.W(9)) u_sync (
    .clk_i(sys_clk_i),
    .rst_b_i(rst_b),
    .d_i({debug_break_i, fault_event_i}),
    .q_o(async_sync)
);

// ----------------------------------------------------------------------------
// Register file
// ----------------------------------------------------------------------------
reg [5:0] ctrl;
reg [7:0] fd_mask;
reg [5:0] fd_ctrl;
reg [7:0] pin_override_enable;
reg [7:0] port_output_reg;
reg [7:0] low_side_delay_value;
reg [7:0] high_side_delay_value;
reg [7:0] low_side_delay_value_buf;
reg [7:0] high_side_delay_value_buf;
reg ls_pend;
reg hs_pend;
reg fdf;
reg fault_state;

wire fault_now = (|(async_sync[7:0] & fd_mask)) | (async_sync[8] & ~fd_ctrl[`WX_FD_DBD]);
wire pgm = ctrl[`WX_CTRL_PGM];
wire [3:0] channel_deadband_enable = ctrl[3:0];
// A write lands only at the edge where the master sees waitrequest low.
wire wr_ok = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
wire rd_go = avs_read_i && avs_waitrequest_o;
wire [7:0] wb = avs_writedata_i[7:0];

// Waitrequest drops one cycle after a request, so each access takes two edges.
always @(posedge sys_clk_i or negedge rst_b) begin
    if (!rst_b) begin
        avs_waitrequest_o <= 1'b1;
        avs_readdata_o <= `WX_RDATA_ZERO;
    end else begin
        avs_waitrequest_o <= ~((avs_read_i || avs_write_i) && avs_waitrequest_o);
        if (rd_go) begin
            case (avs_address_i)
                `WX_REG_CTRL: avs_readdata_o <= {26'h0000000, ctrl};
                `WX_REG_FDMASK: avs_readdata_o <= {24'h000000, fd_mask};
                `WX_REG_FDCTRL: avs_readdata_o <= {26'h0000000, fd_ctrl};
                `WX_REG_STATUS: avs_readdata_o <= {30'h00000000, fault_state, fdf};
                `WX_REG_OVEN: avs_readdata_o <= {24'h000000, pin_override_enable};
                `WX_REG_LOW_SIDE_DELAY_VALUE: avs_readdata_o <= {24'h000000, low_side_delay_value};
                `WX_REG_HIGH_SIDE_DELAY_VALUE: avs_readdata_o <= {24'h000000, high_side_delay_value};
                `WX_REG_DTLSBUF: avs_readdata_o <= {24'h000000, low_side_delay_value_buf};
                `WX_REG_DTHSBUF: avs_readdata_o <= {24'h000000, high_side_delay_value_buf};
                `WX_REG_PORT: avs_readdata_o <= {24'h000000, port_output_reg};
                default: avs_readdata_o <= `WX_RDATA_ZERO;
            endcase
        end
    end
end

always @(posedge sys_clk_i or negedge rst_b) begin
    if (!rst_b) begin
        ctrl <= `WX_CTRL_RST;
        fd_mask <= `WX_BYTE_RST;
        fd_ctrl <= `WX_FDCTRL_RST;
        pin_override_enable <= `WX_BYTE_RST;
        port_output_reg <= `WX_BYTE_RST;
        low_side_delay_value <= `WX_BYTE_RST;
        high_side_delay_value <= `WX_BYTE_RST;
        low_side_delay_value_buf <= `WX_BYTE_RST;
        high_side_delay_value_buf <= `WX_BYTE_RST;
        ls_pend <= 1'b0;
        hs_pend <= 1'b0;
        fdf <= 1'b0;
    end else begin
        if (update_i && ls_pend) begin
            low_side_delay_value <= low_side_delay_value_buf;
            ls_pend <= 1'b0;
        end
        if (update_i && hs_pend) begin
            high_side_delay_value <= high_side_delay_value_buf;
            hs_pend <= 1'b0;
        end
        if (wr_ok) begin
            case (avs_address_i)
                `WX_REG_CTRL: ctrl <= wb[5:0];
                `WX_REG_FDMASK: fd_mask <= wb;
                `WX_REG_FDCTRL: fd_ctrl <= {wb[`WX_FD_HALT], wb[`WX_FD_DBD], 1'b0, wb[2:0]};
                `WX_REG_OVEN: begin
                    if (!fault_state) begin
                        pin_override_enable <= wb;
                    end
                end
                `WX_REG_DTBOTH: begin
                    low_side_delay_value_buf <= wb;
                    high_side_delay_value_buf <= wb;
                    ls_pend <= 1'b1;
                    hs_pend <= 1'b1;
                end
                `WX_REG_LOW_SIDE_DELAY_VALUE: low_side_delay_value <= wb;
                `WX_REG_HIGH_SIDE_DELAY_VALUE: high_side_delay_value <= wb;
                `WX_REG_DTLSBUF: begin
                    low_side_delay_value_buf <= wb;
                    ls_pend <= 1'b1;
                end
                `WX_REG_DTHSBUF: begin
                    high_side_delay_value_buf <= wb;
                    hs_pend <= 1'b1;
                end
                `WX_REG_PORT: port_output_reg <= wb;
                default: ;
            endcase
        end
        // A new fault wins over a software clear in the same cycle.
        if (fault_now) begin
            fdf <= 1'b1;
        end else if (wr_ok && avs_address_i == `WX_REG_STATUS && wb[`WX_FLAG_FDF]) begin
            fdf <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------------------
// Fault restore
// ----------------------------------------------------------------------------
always @(posedge sys_clk_i or negedge rst_b) begin
    if (!rst_b) begin
        fault_state <= 1'b0;
    end else begin
        if (fault_now) begin
            fault_state <= 1'b1;
        end else if (fd_ctrl[`WX_FD_MODE] && update_i) begin
            fault_state <= 1'b0;
        end else if (!fd_ctrl[`WX_FD_MODE] && !fdf && update_i) begin
            fault_state <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------------------
// Dead-band inserters
// ----------------------------------------------------------------------------
wire [3:0] ls_w;
wire [3:0] hs_w;
wire [3:0] busy_w;
// Common waveform mode feeds channel A to every generator.
wire [3:0] dti_in = ctrl[`WX_CTRL_CWCM] ? {4{waveform_gen_i[0]}} : waveform_gen_i;

genvar gi;
generate
    for (gi = 0; gi < `WX_NCH; gi = gi + 1) begin : g_dti
        wx_dead_band_inserter u_dti (
            .clk_i(sys_clk_i),
            .rst_b_i(rst_b),
            .wave_i(dti_in[gi]),
            .low_side_delay_value_i(low_side_delay_value),
            .high_side_delay_value_i(high_side_delay_value),
            .low_side_out_o(ls_w[gi]),
            .high_side_out_o(hs_w[gi]),
            .busy_o(busy_w[gi])
        );
    end
endgenerate

// ----------------------------------------------------------------------------
// Port override
// ----------------------------------------------------------------------------
function [7:0] wx_pair_mask;
    input [3:0] en;
    begin
        wx_pair_mask = {en[3], en[3], en[2], en[2], en[1], en[1], en[0], en[0]};
    end
endfunction

reg [7:0] next_port;
reg [7:0] next_oe;
wire [7:0] dti_pins = {hs_w[3], ls_w[3], hs_w[2], ls_w[2], hs_w[1], ls_w[1], hs_w[0], ls_w[0]};
wire [7:0] owned = wx_pair_mask(channel_deadband_enable);

integer pi;
always @* begin
    next_port = port_normal_i;
    next_oe = compare_output_enable_i;
    for (pi = 0; pi < `WX_NPIN; pi = pi + 1) begin
        if (pgm) begin
            next_port[pi] = pin_override_enable[pi] ? waveform_gen_i[0] : low_side_delay_value[pi];
            next_oe[pi] = pin_override_enable[pi] | high_side_delay_value[pi];
        end else if (owned[pi]) begin
            next_port[pi] = dti_pins[pi];
            next_oe[pi] = pin_override_enable[pi];
        end
    end
    if (fault_now || fault_state) begin
        next_oe = next_oe & ~(owned | {`WX_NPIN{pgm}});
    end
end

always @(posedge sys_clk_i or negedge rst_b) begin
    if (!rst_b) begin
        port_out_o <= `WX_BYTE_RST;
        port_oe_o <= `WX_BYTE_RST;
        timer_halt_o <= 1'b0;
        fault_o <= 1'b0;
    end else begin
        port_out_o <= next_port;
        port_oe_o <= next_oe;
        timer_halt_o <= fd_ctrl[`WX_FD_HALT] & (|(busy_w & channel_deadband_enable)) & ~pgm;
        fault_o <= fault_now | fault_state;
    end
end

endmodule // wx_waveform_extension
`default_nettype wire

/* File: tb/wx_waveform_extension_asserts.sv */
// Checker for the waveform extension top, shadowing control writes seen on the bus.
// Assumes it is bound to the top module and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module wx_waveform_extension_asserts (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic avs_waitrequest_o,
    input wire logic [3:0] waveform_gen_i,
    input wire logic [7:0] port_normal_i,
    input wire logic [7:0] compare_output_enable_i,
    input wire logic update_i,
    input wire logic [7:0] fault_event_i,
    input wire logic [7:0] port_out_o,
    input wire logic [7:0] port_oe_o,
    input wire logic timer_halt_o,
    input wire logic fault_o
);
    // ------------------------------------------------------------------
    // Shadow registers
    // ------------------------------------------------------------------
    // Checks gated by ok wait eight quiet cycles after any write, so settling is not judged.
    logic [7:0] ctrl, oven, mask, fdc, age, own, d, prev_out;
    logic ok;
    assign own = {{2{ctrl[3]}}, {2{ctrl[2]}}, {2{ctrl[1]}}, {2{ctrl[0]}}};
    assign ok = (age == 8'h08);
    assign d = port_out_o ^ prev_out;
    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl <= 8'h00;
            oven <= 8'h00;
            mask <= 8'h00;
            fdc <= 8'h00;
            age <= 8'h00;
            prev_out <= 8'h00;
        end else begin
            prev_out <= port_out_o;
            if (!ok)
                age <= age + 8'h01;
            if (avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]) begin
                age <= 8'h00;
                case (avs_address_i)
                    4'h0: ctrl <= avs_writedata_i[7:0] & 8'h3f;
                    4'h1: mask <= avs_writedata_i[7:0];
                    4'h2: fdc <= avs_writedata_i[7:0];
                    4'h4: if (!fault_o) oven <= avs_writedata_i[7:0];
                    default: ;
                endcase
            end
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    chk_plain_pass: assert property (
        ok && ctrl == 8'h00 |-> port_out_o == $past(port_normal_i) && port_oe_o == $past(compare_output_enable_i))
        else $error("port value not passed through");
    chk_pair_apart: assert property (
        ok && !ctrl[5] |-> (port_out_o & (port_out_o >> 1) & 8'h55 & own) == 8'h00)
        else $error("both sides of a pair on");
    chk_no_joint: assert property (
        ok && !ctrl[5] && $past(ok) |-> (d & (d >> 1) & 8'h55 & own) == 8'h00)
        else $error("pair sides switched together");
    chk_owned_drive: assert property (
        ok && !ctrl[5] && !fault_o && !$past(fault_o) && !$past(fault_o, 2)
        |-> port_oe_o == ((oven & own) | ($past(compare_output_enable_i) & ~own)))
        else $error("pin drive enable wrong");
    chk_fault_fast: assert property (
        ok && $rose((fault_event_i & mask) != 8'h00) |-> ##[1:3] (port_oe_o & (ctrl[5] ? 8'hff : own)) == 8'h00)
        else $error("fault did not disable outputs");
    chk_hold_fault: assert property (
        fault_o && (fault_event_i & mask) != 8'h00 |=> fault_o)
        else $error("fault left while event active");
    chk_resume_upd: assert property (
        $fell(fault_o) |-> $past(update_i) || $past(update_i, 2))
        else $error("fault left without update");
    chk_halt_gate: assert property (
        timer_halt_o |-> fdc[5] || $past(fdc[5]))
        else $error("timer halted while halt disabled");
    chk_chan_a: assert property (
        ok && ctrl[5] && !fault_o |-> ((port_out_o ^ {8{$past(waveform_gen_i[0])}}) & oven) == 8'h00)
        else $error("override pin not showing channel A");
    chk_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    cover property (ok && timer_halt_o);
    cover property ($rose(fault_o));
    cover property (ok && ctrl[5] && update_i);
endmodule // wx_waveform_extension_asserts
bind wx_waveform_extension wx_waveform_extension_asserts wx_waveform_extension_asserts_inst (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i), .avs_waitrequest_o(avs_waitrequest_o),
    .waveform_gen_i(waveform_gen_i), .port_normal_i(port_normal_i), .compare_output_enable_i(compare_output_enable_i),
    .update_i(update_i), .fault_event_i(fault_event_i), .port_out_o(port_out_o), .port_oe_o(port_oe_o),
    .timer_halt_o(timer_halt_o), .fault_o(fault_o));
`default_nettype wire

/* File: tb/wx_timer_model.sv */
// Timer model feeding the extension: up counter, four compare waveforms, update pulse.
// Assumes the same clock as the extension and a halt request from it.
`timescale 1ns/1ps
`default_nettype none
module wx_timer_model (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic halt_i,
    input wire logic [7:0] period_i,
    input wire logic [31:0] compare_i,
    output logic [3:0] wave_o,
    output logic update_o
);
    logic [7:0] count;
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count <= 8'h00;
            wave_o <= 4'h0;
            update_o <= 1'b0;
        end else begin
            update_o <= 1'b0;
            if (!halt_i) begin
                count <= (count == period_i) ? 8'h00 : count + 8'h01;
                update_o <= (count == period_i);
                for (int k = 0; k < 4; k++)
                    wave_o[k] <= (count < compare_i[8*k +: 8]);
            end
        end
    end
endmodule // wx_timer_model
`default_nettype wire

/* File: tb/wx_waveform_extension_test.sv */
// Self-checking bench for the waveform extension with a timer model on its far side.
// Assumes the design files are compiled first; read answers are checked from a queue.
`timescale 1ns/1ps
`default_nettype none
module wx_waveform_extension_test;
    logic sys_clk_i, rst_b_i, avs_read_i, avs_write_i, update_i, debug_break_i, timer_halt_o, fault_o;
    logic avs_waitrequest_o;
    logic [3:0] avs_address_i, avs_byteenable_i, waveform_gen_i, w_q;
    logic [31:0] avs_writedata_i, avs_readdata_o;
    logic [7:0] port_normal_i, compare_output_enable_i, fault_event_i, port_out_o, port_oe_o;
    logic [7:0] per, dls, dhs, pat, pen, ex;
    logic [7:0] exp_q[$];
    int miscompares, compares, i, n;
    wx_waveform_extension wx_waveform_extension_inst (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .waveform_gen_i(waveform_gen_i), .port_normal_i(port_normal_i),
        .compare_output_enable_i(compare_output_enable_i), .update_i(update_i), .fault_event_i(fault_event_i),
        .debug_break_i(debug_break_i), .port_out_o(port_out_o), .port_oe_o(port_oe_o),
        .timer_halt_o(timer_halt_o), .fault_o(fault_o));
    wx_timer_model wx_timer_model_inst (.clk_i(sys_clk_i), .rst_b_i(rst_b_i), .halt_i(timer_halt_o),
        .period_i(per), .compare_i(32'h0e0c0a08), .wave_o(waveform_gen_i), .update_o(update_i));
    initial begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic final_report();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] e);
        compares++;
        if (got !== e) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, e);
            miscompares++;
        end
    endtask
    task automatic bound(input int t, input int lim);
        if (t >= lim) begin
            miscompares++;
            final_report();
        end
    endtask
    task automatic bus(input logic [3:0] a, input logic r, input logic [7:0] d, input logic [3:0] be);
        int t;
        @(posedge sys_clk_i);
        avs_address_i <= a;
        avs_read_i <= r;
        avs_write_i <= !r;
        avs_writedata_i <= {24'h000000, d};
        avs_byteenable_i <= be;
        t = 0;
        do begin @(posedge sys_clk_i); t++; end while (avs_waitrequest_o !== 1'b0 && t < 50);
        bound(t, 50);
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(a, 1'b0, d, 4'hf);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus(a, 1'b1, 8'h00, 4'hf);
    endtask
    task automatic wait_upd();
        int t;
        t = 0;
        do begin @(posedge sys_clk_i); t++; end while (update_i !== 1'b1 && t < 400);
        bound(t, 400);
    endtask
    // Waits for a waveform edge, then counts edges until the pin is seen high.
    task automatic meas(input int ch, input int pin, input logic lvl, input logic [7:0] e);
        int t;
        t = 0;
        do begin @(posedge sys_clk_i); t++; end while (!(waveform_gen_i[ch] === lvl && w_q[ch] !== lvl) && t < 400);
        bound(t, 400);
        t = 0;
        do begin @(posedge sys_clk_i); t++; end while (port_out_o[pin] !== 1'b1 && t < 300);
        cmp(t[7:0], e);
    endtask
    always @(posedge sys_clk_i) begin
        w_q <= waveform_gen_i;
        if (avs_read_i && avs_waitrequest_o === 1'b0)
            cmp(avs_readdata_o[7:0], exp_q.pop_front());
    end
    initial begin
        #4000000;
        miscompares++;
        final_report();
    end
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {rst_b_i, avs_read_i, avs_write_i, debug_break_i} = 4'h0;
        {avs_address_i, avs_byteenable_i, avs_writedata_i, fault_event_i} = 48'h0;
        per = 8'hff;
        n = $urandom(32'h7f980243);
        port_normal_i = $urandom;
        compare_output_enable_i = $urandom;
        dls = 8'h01 + $urandom % 6;
        dhs = 8'h01 + $urandom % 6;
        repeat (16) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        for (i = 0; i < 16; i++)
            if (i != 5) rd(i[3:0], 8'h00);
        cmp(port_out_o, port_normal_i);
        cmp(port_oe_o, compare_output_enable_i);
        wr(4'h5, dls);
        wr(4'h9, dhs);
        rd(4'h6, 8'h00);
        rd(4'h8, dls);
        rd(4'h9, dhs);
        wait_upd();
        per <= 8'd20;
        rd(4'h6, dls);
        rd(4'h7, dhs);
        wr(4'h0, 8'h0f);
        wr(4'h4, 8'hff);
        for (i = 0; i < 4; i++)
            meas(i, 2 * i, 1'b1, dls + 8'h02);
        meas(0, 1, 1'b0, dhs + 8'h02);
        wr(4'h2, 8'h20);
        n = 0;
        repeat (25) @(posedge sys_clk_i) n += (timer_halt_o === 1'b1);
        cmp(n != 0, 8'h01);
        wr(4'h2, 8'h00);
        wr(4'h0, 8'h05);
        wr(4'h4, 8'h0f);
        bus(4'h4, 1'b0, 8'hff, 4'h0);
        rd(4'h4, 8'h0f);
        ex = 8'h03 | (compare_output_enable_i & 8'hcc);
        cmp(port_oe_o, ex);
        cmp(port_out_o & 8'hcc, port_normal_i & 8'hcc);
        wr(4'h1, 8'h04);
        // Cases: latched event, cycle event, cycle debug break, ignored debug break.
        for (i = 0; i < 4; i++) begin
            wr(4'h2, i == 0 ? 8'h00 : (i == 3 ? 8'h14 : 8'h04));
            fault_event_i <= 8'hfb;
            repeat (10) @(posedge sys_clk_i);
            cmp(port_oe_o, ex);
            fault_event_i <= (i < 2) ? 8'h04 : 8'h00;
            debug_break_i <= (i >= 2);
            repeat (4) @(posedge sys_clk_i);
            cmp(port_oe_o, i == 3 ? ex : compare_output_enable_i & 8'hcc);
            rd(4'h3, i == 3 ? 8'h01 : 8'h03);
            fault_event_i <= 8'h00;
            debug_break_i <= 1'b0;
            repeat (4) @(posedge sys_clk_i);
            wait_upd();
            repeat (3) @(posedge sys_clk_i);
            if (i == 0) begin
                cmp(port_oe_o, compare_output_enable_i & 8'hcc);
                wr(4'h3, 8'h01);
                wait_upd();
                repeat (3) @(posedge sys_clk_i);
            end
            cmp(port_oe_o, ex);
            rd(4'h3, i == 0 ? 8'h00 : 8'h01);
        end
        pat = $urandom;
        pen = $urandom;
        wr(4'h4, 8'h00);
        wait_upd();
        wr(4'h0, 8'h20);
        wr(4'h8, pat);
        wr(4'h9, pen);
        cmp(port_out_o, dls);
        cmp(port_oe_o, dhs);
        wait_upd();
        repeat (3) @(posedge sys_clk_i);
        cmp(port_out_o, pat);
        cmp(port_oe_o, pen);
        wr(4'h4, 8'h0f);
        repeat (3) @(posedge sys_clk_i);
        cmp(port_oe_o, pen | 8'h0f);
        cmp(port_out_o & 8'hf0, pat & 8'hf0);
        wr(4'h7, 8'haa);
        wr(4'ha, 8'h5a);
        repeat (3) @(posedge sys_clk_i);
        cmp(port_oe_o, 8'haf);
        rd(4'ha, 8'h5a);
        final_report();
    end
endmodule // wx_waveform_extension_test
`default_nettype wire
